// [logic/i2cmr_defines.svh]
`ifndef I2CMR_DEFINES_SVH
`define I2CMR_DEFINES_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define I2CMR_OFF_CTRL 2'h0
`define I2CMR_OFF_STAT 2'h1
`define I2CMR_OFF_BUF 2'h2
`define I2CMR_OFF_RATE 2'h3
// ------------------------------------------------------------
// control bits
// ------------------------------------------------------------
`define I2CMR_C_EN 0
`define I2CMR_C_RX 1
`define I2CMR_C_ACK 2
`define I2CMR_C_ACKV 3
`define I2CMR_C_STOP 4
`define I2CMR_C_IE 5
// ------------------------------------------------------------
// status bits
// ------------------------------------------------------------
`define I2CMR_S_FULL 0
`define I2CMR_S_OVF 1
`define I2CMR_S_WRITE_COLLISION_FLAG 2
`define I2CMR_S_EVT 3
`define I2CMR_S_ARB 4
`define I2CMR_S_STOPD 5
`define I2CMR_S_STARTD 6
// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define I2CMR_RATE_RST 8'h04
`define I2CMR_LAST_BIT 3'h7
`endif

// [logic/i2cmr_pkg.sv]
package i2cmr_pkg;
  // ----------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------
  typedef enum logic [8:0] {
    I2CMR_IDLE = 9'h001,
    I2CMR_RX = 9'h002,
    I2CMR_ACK_LO = 9'h004,
    I2CMR_ACK_HI = 9'h008,
    I2CMR_STOP_A = 9'h010,
    I2CMR_STOP_B = 9'h020,
    I2CMR_STOP_C = 9'h040,
    I2CMR_STOP_D = 9'h080,
    I2CMR_STOP_E = 9'h100
  } i2cmr_state_t;
endpackage

// [logic/i2cmr_top.sv]
// Functional notes
// R1: receive request ignored unless port idle
// R2: each rollover toggles clock, every second one (clock released) shifts data in
// R3: eighth fall ends byte, loads buffer, holds
// R4: full flag set on load, cleared by read
// R5: byte arriving while full sets overflow
// R6: buffer write during receive sets collision
// R7: acknowledge pulls clock low, drives value
// R8: software picks acknowledge value beforehand
// R9: acknowledge clock high one period, then idle
// R10: buffer write during acknowledge sets collision
// R11: stop drives data low, then counts period
// R12: release clock, data one period later
// R13: data rising with clock high flags stop
// R14: period after stop, clear request, event
// R15: buffer write during stop sets collision
// R16: sleeping with interrupt enabled wakes on event
// R17: reset disables port, aborts transfer
// R18: start/stop status cleared when disabled
// R19: master takes bus when free only; the code does not check the bus, an idle port starts any request
// R20: stop seen while busy raises event
// R21: data mismatch during acknowledge loses arbitration
// R22: software handles each byte in order
// R23: every reload takes the rate register
// R24: arbitration loss flags and returns idle
`timescale 1ns/1ps
`default_nettype none
`include "i2cmr_defines.svh"

module i2cmr_top
  import i2cmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep,
  output logic wake,
  output logic event_irq
);

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  function automatic logic hit(input logic [1:0] a,
                               input logic [1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic scl_m, scl_s, sda_m, sda_s, sda_d;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  wire logic stop_seen = scl_s & sda_s & ~sda_d;
  wire logic start_seen = scl_s & ~sda_s & sda_d;

  // ----------------------------------------------------------
  // state
  // ----------------------------------------------------------
  i2cmr_state_t state;
  logic [7:0] cnt, rate, shreg, buffer;
  logic [2:0] nbits;
  logic run, enable, ie, ack_value;
  logic rx_en, ack_req, stop_req;
  logic full, ovf, write_collision_flag, evt, arb, stop_det, start_det;

  wire logic roll = run & (cnt == 8'h00);
  wire logic wr_ctrl = wr & hit(addr, `I2CMR_OFF_CTRL);
  wire logic wr_stat = wr & hit(addr, `I2CMR_OFF_STAT);
  wire logic wr_buf = wr & hit(addr, `I2CMR_OFF_BUF);
  wire logic rd_buf = rd & hit(addr, `I2CMR_OFF_BUF);
  wire logic busy = (state != I2CMR_IDLE);
  wire logic byte_done = (state == I2CMR_RX) & roll & ~scl_oe &
                         (nbits == `I2CMR_LAST_BIT);
  wire logic ack_done = (state == I2CMR_ACK_HI) & roll;
  wire logic stop_done = (state == I2CMR_STOP_E) & roll;
  wire logic arb_lost = (state == I2CMR_ACK_HI) & scl_s &
                        ~sda_oe & ~sda_s;
  wire logic [7:0] next_shreg = {shreg[6:0], sda_s};

  // ----------------------------------------------------------
  // sequencer, rate counter and pin drive
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // R17
      state <= I2CMR_IDLE;
      cnt <= 8'h00;
      run <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_en <= 1'b0;
      ack_req <= 1'b0;
      stop_req <= 1'b0;
      shreg <= 8'h00;
      nbits <= 3'h0;
    end else if (!enable) begin // R17
      state <= I2CMR_IDLE;
      run <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_en <= 1'b0;
      ack_req <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      if (roll) begin
        cnt <= rate; // R23
      end else if (run) begin
        cnt <= cnt - 8'h01;
      end
      case (state)
        I2CMR_IDLE: begin
          if (wr_ctrl) begin // R1
            if (wdata[`I2CMR_C_STOP]) begin
              stop_req <= 1'b1;
              sda_oe <= 1'b1; // R11
              state <= I2CMR_STOP_A;
            end else if (wdata[`I2CMR_C_ACK]) begin
              ack_req <= 1'b1;
              scl_oe <= 1'b1; // R7
              sda_oe <= ~wdata[`I2CMR_C_ACKV]; // R7
              run <= 1'b1;
              cnt <= rate; // R23
              state <= I2CMR_ACK_LO;
            end else if (wdata[`I2CMR_C_RX]) begin
              rx_en <= 1'b1;
              scl_oe <= 1'b1;
              sda_oe <= 1'b0;
              run <= 1'b1;
              cnt <= rate; // R23
              nbits <= 3'h0;
              state <= I2CMR_RX;
            end
          end
        end
        I2CMR_RX: begin
          if (roll) begin
            scl_oe <= ~scl_oe; // R2
            if (scl_oe == 1'b0) begin
              shreg <= next_shreg; // R2
              nbits <= nbits + 3'h1;
              if (nbits == `I2CMR_LAST_BIT) begin
                rx_en <= 1'b0; // R3
                run <= 1'b0; // R3
                scl_oe <= 1'b1; // R3
                state <= I2CMR_IDLE;
              end
            end
          end
        end
        I2CMR_ACK_LO: begin
          if (roll) begin
            scl_oe <= 1'b0; // R9
            run <= 1'b0;
            state <= I2CMR_ACK_HI;
          end
        end
        I2CMR_ACK_HI: begin
          if (arb_lost) begin // R24
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            run <= 1'b0;
            ack_req <= 1'b0;
            state <= I2CMR_IDLE;
          end else if (!run && scl_s) begin
            run <= 1'b1; // R9
            cnt <= rate;
          end else if (roll) begin
            scl_oe <= 1'b1; // R9
            run <= 1'b0;
            ack_req <= 1'b0;
            state <= I2CMR_IDLE;
          end
        end
        I2CMR_STOP_A: begin
          if (!sda_s) begin
            run <= 1'b1; // R11
            cnt <= rate;
            state <= I2CMR_STOP_B;
          end
        end
        I2CMR_STOP_B: begin
          if (roll) begin
            scl_oe <= 1'b0; // R12
            state <= I2CMR_STOP_C;
          end
        end
        I2CMR_STOP_C: begin
          if (roll) begin
            sda_oe <= 1'b0; // R12
            run <= 1'b0;
            state <= I2CMR_STOP_D;
          end
        end
        I2CMR_STOP_D: begin
          if (stop_seen) begin
            run <= 1'b1; // R14
            cnt <= rate;
            state <= I2CMR_STOP_E;
          end
        end
        I2CMR_STOP_E: begin
          if (roll) begin
            stop_req <= 1'b0; // R14
            run <= 1'b0;
            state <= I2CMR_IDLE;
          end
        end
        default: begin
          state <= I2CMR_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // software settings
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= 1'b0;
      ie <= 1'b0;
      ack_value <= 1'b0;
      rate <= `I2CMR_RATE_RST;
    end else begin
      if (wr_ctrl) begin
        enable <= wdata[`I2CMR_C_EN];
        ie <= wdata[`I2CMR_C_IE];
        ack_value <= wdata[`I2CMR_C_ACKV];
      end
      if (wr & hit(addr, `I2CMR_OFF_RATE)) begin
        rate <= wdata;
      end
    end
  end

  // ----------------------------------------------------------
  // buffer and flags, set wins over clear
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buffer <= 8'h00;
      full <= 1'b0;
      ovf <= 1'b0;
      write_collision_flag <= 1'b0;
      evt <= 1'b0;
      arb <= 1'b0;
    end else begin
      if (byte_done) begin
        buffer <= next_shreg; // R3
      end else if (wr_buf && !busy) begin
        buffer <= wdata;
      end
      if (byte_done) begin
        full <= 1'b1; // R4
      end else if (rd_buf) begin
        full <= 1'b0; // R4
      end
      if (byte_done && full) begin
        ovf <= 1'b1; // R5
      end else if (wr_stat && wdata[`I2CMR_S_OVF]) begin
        ovf <= 1'b0;
      end
      if (wr_buf && busy) begin
        write_collision_flag <= 1'b1; // R6 R10 R15
      end else if (wr_stat && wdata[`I2CMR_S_WRITE_COLLISION_FLAG]) begin
        write_collision_flag <= 1'b0;
      end
      if (byte_done || ack_done || stop_done ||
          (stop_seen && start_det)) begin
        evt <= 1'b1; // R3 R14 R20
      end else if (wr_stat && wdata[`I2CMR_S_EVT]) begin
        evt <= 1'b0;
      end
      if (arb_lost) begin
        arb <= 1'b1; // R21 R24
      end else if (wr_stat && wdata[`I2CMR_S_ARB]) begin
        arb <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // bus condition monitor
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stop_det <= 1'b0;
      start_det <= 1'b0;
    end else if (!enable) begin
      stop_det <= 1'b0; // R18
      start_det <= 1'b0; // R18
    end else if (stop_seen) begin
      stop_det <= 1'b1; // R13
      start_det <= 1'b0;
    end else if (start_seen) begin
      start_det <= 1'b1;
      stop_det <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // read port and outputs
  // ----------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `I2CMR_OFF_CTRL: rdata <= {2'h0, ie, stop_req,
                                   ack_value, ack_req, rx_en, enable};
        `I2CMR_OFF_STAT: rdata <= {1'b0, start_det, stop_det, arb,
                                   evt, write_collision_flag, ovf, full};
        `I2CMR_OFF_BUF: rdata <= buffer;
        default: rdata <= rate;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      wake <= 1'b0;
      event_irq <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      wake <= sleep & ie & evt; // R16
      event_irq <= ie & evt; // R20
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  property p_rx_ignored;
    @(posedge clk) disable iff (rst)
    busy && wr_ctrl && wdata[`I2CMR_C_RX] && !rx_en |=> !rx_en;
  endproperty
  a_rx_ignored: assert property (p_rx_ignored) // R1
    else $error("receive request taken while busy");

  property p_byte_end;
    @(posedge clk) disable iff (rst)
    byte_done |=> full && evt && !rx_en && !run && scl_oe &&
                  (buffer == $past(next_shreg));
  endproperty
  a_byte_end: assert property (p_byte_end) // R3
    else $error("byte completion effects missing");

  property p_full_clear;
    @(posedge clk) disable iff (rst)
    rd_buf && !byte_done |=> !full;
  endproperty
  a_full_clear: assert property (p_full_clear) // R4
    else $error("buffer read did not clear full");

  property p_overflow;
    @(posedge clk) disable iff (rst)
    byte_done && full |=> ovf;
  endproperty
  a_overflow: assert property (p_overflow) // R5
    else $error("overflow not flagged");

  property p_collision;
    @(posedge clk) disable iff (rst)
    wr_buf && busy && !byte_done |=> write_collision_flag && $stable(buffer);
  endproperty
  a_collision: assert property (p_collision) // R6
    else $error("busy buffer write not refused");

  property p_ack_start;
    @(posedge clk) disable iff (rst)
    !busy && enable && wr_ctrl && wdata[`I2CMR_C_ACK] &&
    !wdata[`I2CMR_C_STOP] |=> scl_oe && (sda_oe == !ack_value);
  endproperty
  a_ack_start: assert property (p_ack_start) // R7
    else $error("acknowledge drive wrong");

  property p_stop_drive;
    @(posedge clk) disable iff (rst)
    (state == I2CMR_STOP_C) && roll |=> !sda_oe && !scl_oe;
  endproperty
  a_stop_drive: assert property (p_stop_drive) // R12
    else $error("stop release order wrong");

  property p_stop_seen;
    @(posedge clk) disable iff (rst)
    enable && stop_seen |=> stop_det;
  endproperty
  a_stop_seen: assert property (p_stop_seen) // R13
    else $error("stop not detected");

  property p_disabled;
    @(posedge clk) disable iff (rst)
    !enable |=> !stop_det && !start_det && !busy;
  endproperty
  a_disabled: assert property (p_disabled) // R18
    else $error("status kept while disabled");

  property p_arb;
    @(posedge clk) disable iff (rst)
    arb_lost |=> arb && !busy && !scl_oe && !sda_oe;
  endproperty
  a_arb: assert property (p_arb) // R24
    else $error("arbitration loss not handled");

endmodule
`default_nettype wire

// [verif/i2cmr_slave_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// slave that sends one byte per arm, msb first
// ------------------------------------------------------------
module i2cmr_slave_model (
  input wire logic scl,
  input wire logic arm,
  input wire logic [7:0] tx_byte,
  input wire logic hold_low,
  output logic sda_low
);
  logic active;
  logic bit_low;
  logic [2:0] idx;
  initial begin
    active = 1'b0;
    bit_low = 1'b0;
    idx = 3'h7;
  end
  always @(posedge arm) begin
    active = 1'b1;
    idx = 3'h7;
    bit_low = ~tx_byte[7];
  end
  // data changes a hold time after the clock falls
  always @(negedge scl) begin
    if (active) begin
      #150;
      if (idx == 3'h0) begin
        active = 1'b0;
        bit_low = 1'b0;
      end else begin
        idx = idx - 3'h1;
        bit_low = ~tx_byte[idx];
      end
    end
  end
  // released line floats to the pull-up
  assign sda_low = hold_low | bit_low;
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "i2cmr_defines.svh"
module testbench;
  logic clk, rst, wr, rd, sleep, arm, hold_low;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, tx_byte;
  logic scl_out, scl_oe, sda_out, sda_oe, wake, event_irq;
  wire logic sda_low;
  wire logic scl = scl_oe ? scl_out : 1'b1;
  wire logic sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  int n_mismatch = 0;
  int comparisons = 0;
  i2cmr_top u_i2cmr_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sleep(sleep), .wake(wake), .event_irq(event_irq));
  i2cmr_slave_model u_i2cmr_slave_model (.scl(scl), .arm(arm),
    .tx_byte(tx_byte), .hold_low(hold_low), .sda_low(sda_low));
  always #50 clk = ~clk;
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic wait_evt(output int t_scl, output int t_sda);
    int n;
    t_scl = -1;
    t_sda = -1;
    for (n = 0; n < 400 && event_irq !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (t_scl < 0 && scl_oe === 1'b0) t_scl = n;
      if (t_sda < 0 && sda_oe === 1'b0) t_sda = n;
    end
    check({7'h0, event_irq}, 8'h01);
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_rx(input logic [7:0] b, input logic [7:0] exp_stat);
    logic [7:0] d;
    int a, c;
    arm = 1'b0;
    tx_byte = b;
    wreg(`I2CMR_OFF_CTRL, 8'h23);
    @(posedge clk);
    #1;
    arm = 1'b1;
    wreg(`I2CMR_OFF_BUF, 8'h5A);
    wait_evt(a, c);
    check({7'h0, scl_oe}, 8'h01);
    check({7'h0, wake}, 8'h01);
    rreg(`I2CMR_OFF_CTRL, d);
    check(d & 8'h02, 8'h00);
    rreg(`I2CMR_OFF_STAT, d);
    check(d, exp_stat);
    wreg(`I2CMR_OFF_STAT, 8'h1E);
  endtask
  task automatic t_ack(input logic v);
    logic [7:0] d;
    int a, c;
    wreg(`I2CMR_OFF_CTRL, {4'h2, v, 3'h5});
    #1;
    check({6'h0, scl_oe, sda_oe}, {6'h0, 1'b1, ~v});
    wreg(`I2CMR_OFF_CTRL, {4'h2, v, 3'h3});
    wreg(`I2CMR_OFF_BUF, 8'hC3);
    wait_evt(a, c);
    check({7'h0, scl_oe}, 8'h01);
    rreg(`I2CMR_OFF_CTRL, d);
    check(d & 8'h06, 8'h00);
    rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h04, 8'h04);
    wreg(`I2CMR_OFF_STAT, 8'h1E);
  endtask
  task automatic t_stop;
    logic [7:0] d;
    int a, c;
    rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h40, 8'h00);
    wreg(`I2CMR_OFF_CTRL, 8'h31);
    #1;
    check({6'h0, scl_oe, sda_oe}, 8'h03);
    wreg(`I2CMR_OFF_BUF, 8'h99);
    wait_evt(a, c);
    check(8'(c - a), 8'h04);
    check({6'h0, scl_oe, sda_oe}, 8'h00);
    rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h24, 8'h24);
    rreg(`I2CMR_OFF_CTRL, d);
    check(d & 8'h10, 8'h00);
    wreg(`I2CMR_OFF_STAT, 8'h1E);
  endtask
  task automatic t_arb;
    logic [7:0] d;
    int n;
    hold_low = 1'b1;
    wreg(`I2CMR_OFF_CTRL, 8'h2D);
    d = 8'h00;
    for (n = 0; n < 20 && d[4] !== 1'b1; n++) rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h10, 8'h10);
    check({6'h0, scl_oe, sda_oe}, 8'h00);
    rreg(`I2CMR_OFF_CTRL, d);
    check(d & 8'h04, 8'h00);
    hold_low = 1'b0;
    wreg(`I2CMR_OFF_STAT, 8'h1E);
    rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h20, 8'h20);
    wreg(`I2CMR_OFF_CTRL, 8'h00);
    rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h60, 8'h00);
    wreg(`I2CMR_OFF_CTRL, 8'h21);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    arm = 1'b0;
    wreg(`I2CMR_OFF_CTRL, 8'h23);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    check({6'h0, scl_oe, sda_oe}, 8'h00);
    rreg(`I2CMR_OFF_CTRL, d);
    check(d, 8'h00);
    rreg(`I2CMR_OFF_RATE, d);
    check(d, `I2CMR_RATE_RST);
  endtask
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    logic [7:0] d;
    clk = 1'b0;
    rst = 1'b1;
    {wr, rd, sleep, arm, hold_low} = 5'h00;
    addr = 2'h0;
    wdata = 8'h00;
    tx_byte = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rreg(`I2CMR_OFF_STAT, d);
    check(d, 8'h00);
    rreg(`I2CMR_OFF_RATE, d);
    check(d, `I2CMR_RATE_RST);
    wreg(`I2CMR_OFF_CTRL, 8'h02);
    rreg(`I2CMR_OFF_CTRL, d);
    check(d, 8'h00);
    check({7'h0, scl_oe}, 8'h00);
    wreg(`I2CMR_OFF_CTRL, 8'h21);
    wreg(`I2CMR_OFF_RATE, 8'h03);
    sleep <= 1'b1;
    t_rx(8'hA5, 8'h0D);
    rreg(`I2CMR_OFF_BUF, d);
    check(d, 8'hA5);
    rreg(`I2CMR_OFF_STAT, d);
    check(d & 8'h01, 8'h00);
    t_rx(8'h3C, 8'h0D);
    t_rx(8'h81, 8'h0F);
    rreg(`I2CMR_OFF_BUF, d);
    t_ack(1'b0);
    t_arb;
    t_rx(8'h7E, 8'h0D);
    rreg(`I2CMR_OFF_BUF, d);
    check(d, 8'h7E);
    t_ack(1'b1);
    t_stop;
    t_reset;
    tally_and_finish;
  end
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
